// ---- logic/cris_pkg.sv ----
// constants, types and register map of the reset and initialisation block
package cris_pkg;

   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_FUCS     = 8'h00;
   localparam logic [7:0] OFS_PMC      = 8'h08;
   localparam logic [7:0] OFS_SLT      = 8'h10;
   localparam logic [7:0] OFS_SLR      = 8'h18;
   localparam logic [7:0] OFS_TLB      = 8'h20;
   localparam logic [7:0] OFS_MUCR     = 8'h28;
   localparam logic [7:0] OFS_DCMODE   = 8'h30;
   localparam logic [7:0] OFS_DCTEST   = 8'h38;
   localparam logic [7:0] OFS_MFM      = 8'h40;
   localparam logic [7:0] OFS_CC       = 8'h48;
   localparam logic [7:0] OFS_CCCTL    = 8'h50;
   localparam logic [7:0] OFS_MSTAT    = 8'h58;
   localparam logic [7:0] OFS_FVA      = 8'h60;
   localparam logic [7:0] OFS_FFA      = 8'h68;
   localparam logic [7:0] OFS_DFLUSH   = 8'h70;
   localparam logic [7:0] OFS_IFLUSH   = 8'h78;
   localparam logic [7:0] OFS_BCCTL    = 8'h80;
   localparam logic [7:0] OFS_CBUCFG   = 8'h88;
   localparam logic [7:0] OFS_STATUS   = 8'h90;

   // ==========================================================
   // field positions and reset values
   localparam logic [63:0] FUCS_SET_MASK = 64'h0000_0020_8004_0000;
   localparam int          FUCS_IRQ_LSB  = 40;
   localparam logic [63:0] PMC_CLR_MASK  = 64'h0000_0000_0000_FC00;
   localparam int          MFM_TMO_BIT   = 5;
   localparam int          DCTEST_BIT    = 15;
   localparam int          EN_BIT        = 0;
   localparam logic [15:0] CBU_CFG_RST   = 16'h0000;
   localparam int          STAT_IO_BIT   = 0;
   localparam int          STAT_LOCK_BIT = 1;
   localparam int          STAT_RUN_BIT  = 2;

   // ==========================================================
   // types
   typedef enum logic [1:0] {SEQ_HOLD, SEQ_ICINV, SEQ_LOAD, SEQ_RUN} cris_seq_e;

   typedef struct packed {
      logic [31:0] cnt;
      logic        expire;
   } cris_tmr_s;

   typedef struct packed {
      cris_seq_e   seq;
      logic        pg_s1;
      logic        pg_s2;
      logic        rs_s1;
      logic        rs_s2;
      logic        sp_s1;
      logic        sp_s2;
      logic        rx_s1;
      logic        rx_s2;
      logic [3:0]  irq_s1;
      logic [3:0]  irq_s2;
      logic        srom_present;
      logic        io_mode;
      logic [63:0] fucs;
      logic [63:0] pmc;
      logic        tx;
      logic [15:0] tlb_valid;
      logic [15:0] mucr;
      logic [15:0] dcmode;
      logic        dctest;
      logic [15:0] mfm;
      logic        cc_en;
      logic [31:0] cc;
      logic [15:0] mstat;
      logic [63:0] fva;
      logic [63:0] ffa;
      logic        flock;
      logic        bc_en;
      logic [15:0] cbu_cfg;
      logic        icinv;
      logic        dcinv;
      logic        machine_check_trap;
      logic [63:0] rdata;
   } cris_state_s;

endpackage

// ---- logic/cris_timer.sv ----
// no-progress timer of the fetch and decode unit
module cris_timer
   import cris_pkg::*;
#(
   parameter int unsigned TMO_CYCLES = 1000000
) (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_run,
   input  wire logic i_retire,
   output logic      o_expire
);
   import cris_pkg::*;

   localparam logic [31:0] LIMIT = 32'(TMO_CYCLES);

   cris_tmr_s st;
   cris_tmr_s next_st;

   // ==========================================================
   // count cycles without a completed instruction
   always_comb begin
      next_st = st;
      next_st.expire = 1'b0;
      if (!i_run || i_retire) begin
         next_st.cnt = '0;
      end else if (st.cnt == LIMIT - 32'h1) begin
         next_st.cnt    = '0;
         next_st.expire = 1'b1;
      end else begin
         next_st.cnt = st.cnt + 32'h1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_expire = st.expire;

endmodule

// ---- logic/cris_top.sv ----
// reset sequencer, reset-sensitive registers and timeout reset of the cpu
//
// Functional notes
// - reset sequence invalidates whole instruction cache before any boot load.
// - reset leaves data cache disabled, contents untouched.
// - reset leaves backup cache disabled until firmware enables it.
// - after boot load, software drives and samples serial boot pins.
// - cache bus unit starts in its reset-value default configuration.
// - serial line transmit register cleared by reset, drives output pin.
// - fetch control status clears except 37,31,18 set; 43:40 take interrupt pins.
// - reset clears performance counter control bits 15:10.
// - data tlb valid bits cleared by chip reset, kept over timeout.
// - memory control, dcache mode, test bit 15 cleared by chip reset only.
// - miss file mode cleared by chip reset; timeout clears bit 05 only.
// - chip reset disables the cycle counter.
// - fault registers stay locked after capture until fault address is read.
// - write to data cache flush register clears all data cache valid bits.
// - write to instruction cache flush register invalidates instruction cache.
// - instruction cache never snoops memory writes; only flush makes it coherent.
// - no-progress timer expiry raises an internal timeout reset.
// - timeout reset clears only what is needed; other state preserved.
// - after timeout reset, dispatch to the machine-check trap of firmware.
// - ring oscillator while power-good low, external clock pair after.
//
// Our own choices: the plain strobed port and the placing of the registers.
module cris_top
   import cris_pkg::*;
#(
   parameter int unsigned TMO_CYCLES = 1000000
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_power_good,
   input  wire logic        i_sys_reset_n,
   input  wire logic        i_srom_present_n,
   input  wire logic        i_srom_data,
   input  wire logic [3:0]  i_irq_pins,
   input  wire logic        i_srom_load_done,
   input  wire logic        i_instr_retire,
   input  wire logic        i_fault_capture,
   input  wire logic [15:0] i_fault_status,
   input  wire logic [63:0] i_fault_va,
   input  wire logic [63:0] i_fault_formatted_fault_address,
   input  wire logic [7:0]  i_addr,
   input  wire logic [63:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [63:0]      o_rdata,
   output logic             o_cpu_reset,
   output logic             o_boot_load_active,
   output logic             o_icache_inval,
   output logic             o_dcache_inval_all,
   output logic             o_dcache_enable,
   output logic             o_bcache_enable,
   output logic [15:0]      o_cbu_config,
   output logic             o_serial_tx,
   output logic             o_io_mode,
   output logic             o_clk_sel_ext,
   output logic             o_timeout_reset,
   output logic             o_machine_check_trap
);
   import cris_pkg::*;

   cris_state_s st;
   cris_state_s next_st;
   logic        chip_rst;
   logic        tmo_rst;
   logic        wr_hit_fva_rd;

   // ==========================================================
   // no-progress timer
   cris_timer #(
      .TMO_CYCLES (TMO_CYCLES)
   ) u_timer (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_run    (st.seq == SEQ_RUN),
      .i_retire (i_instr_retire),
      .o_expire (tmo_rst)
   );

   // chip reset qualifier and fault address read strobe
   assign chip_rst      = !st.pg_s2 || !st.rs_s2;
   assign wr_hit_fva_rd = i_rd && (i_addr == OFS_FVA);

   // ==========================================================
   // next state
   always_comb begin
      next_st = st;
      // pin synchronisers
      next_st.pg_s1  = i_power_good;
      next_st.pg_s2  = st.pg_s1;
      next_st.rs_s1  = i_sys_reset_n;
      next_st.rs_s2  = st.rs_s1;
      next_st.sp_s1  = i_srom_present_n;
      next_st.sp_s2  = st.sp_s1;
      next_st.rx_s1  = i_srom_data;
      next_st.rx_s2  = st.rx_s1;
      next_st.irq_s1 = i_irq_pins;
      next_st.irq_s2 = st.irq_s1;
      next_st.icinv  = 1'b0;
      next_st.dcinv  = 1'b0;
      next_st.machine_check_trap   = tmo_rst;
      next_st.rdata  = '0;

      // cycle counter runs while enabled
      if (st.cc_en) begin
         next_st.cc = st.cc + 32'h1;
      end

      // reset sequencer
      case (st.seq)
         SEQ_HOLD: begin
            next_st.seq = SEQ_ICINV;
         end
         SEQ_ICINV: begin
            next_st.icinv = 1'b1;
            next_st.seq   = st.srom_present ? SEQ_LOAD : SEQ_RUN;
         end
         SEQ_LOAD: begin
            if (i_srom_load_done) begin
               next_st.io_mode = 1'b1;
               next_st.seq     = SEQ_RUN;
            end
         end
         SEQ_RUN: begin
            next_st.seq = SEQ_RUN;
         end
         default: begin
            next_st.seq = SEQ_HOLD;
         end
      endcase

      // software writes
      if (i_wr) begin
         case (i_addr)
            OFS_FUCS:   next_st.fucs      = i_wdata;
            OFS_PMC:    next_st.pmc       = i_wdata;
            OFS_SLT:    next_st.tx        = i_wdata[EN_BIT];
            OFS_TLB:    next_st.tlb_valid = i_wdata[15:0];
            OFS_MUCR:   next_st.mucr      = i_wdata[15:0];
            OFS_DCMODE: next_st.dcmode    = i_wdata[15:0];
            OFS_DCTEST: next_st.dctest    = i_wdata[DCTEST_BIT];
            OFS_MFM:    next_st.mfm       = i_wdata[15:0];
            OFS_CC:     next_st.cc        = i_wdata[31:0];
            OFS_CCCTL:  next_st.cc_en     = i_wdata[EN_BIT];
            OFS_DFLUSH: next_st.dcinv     = 1'b1;
            OFS_IFLUSH: next_st.icinv     = 1'b1;
            OFS_BCCTL:  next_st.bc_en     = i_wdata[EN_BIT];
            OFS_CBUCFG: next_st.cbu_cfg   = i_wdata[15:0];
            default:    next_st.rdata     = '0;
         endcase
      end

      // software reads, data in the following cycle
      if (i_rd) begin
         case (i_addr)
            OFS_FUCS:   next_st.rdata = st.fucs;
            OFS_PMC:    next_st.rdata = st.pmc;
            OFS_SLT:    next_st.rdata = {63'h0, st.tx};
            OFS_SLR:    next_st.rdata = {63'h0, st.rx_s2};
            OFS_TLB:    next_st.rdata = {48'h0, st.tlb_valid};
            OFS_MUCR:   next_st.rdata = {48'h0, st.mucr};
            OFS_DCMODE: next_st.rdata = {48'h0, st.dcmode};
            OFS_DCTEST: next_st.rdata = {48'h0, st.dctest, 15'h0};
            OFS_MFM:    next_st.rdata = {48'h0, st.mfm};
            OFS_CC:     next_st.rdata = {32'h0, st.cc};
            OFS_CCCTL:  next_st.rdata = {63'h0, st.cc_en};
            OFS_MSTAT:  next_st.rdata = {48'h0, st.mstat};
            OFS_FVA:    next_st.rdata = st.fva;
            OFS_FFA:    next_st.rdata = st.ffa;
            OFS_BCCTL:  next_st.rdata = {63'h0, st.bc_en};
            OFS_CBUCFG: next_st.rdata = {48'h0, st.cbu_cfg};
            OFS_STATUS: next_st.rdata = {61'h0, st.seq == SEQ_RUN, st.flock, st.io_mode};
            default:    next_st.rdata = '0;
         endcase
      end

      // fault capture and unlock; a new capture wins over the unlock
      if (wr_hit_fva_rd) begin
         next_st.flock = 1'b0;
      end
      if (i_fault_capture && (!st.flock || wr_hit_fva_rd)) begin
         next_st.mstat = i_fault_status;
         next_st.fva   = i_fault_va;
         next_st.ffa   = i_fault_formatted_fault_address;
         next_st.flock = 1'b1;
      end

      // timeout reset clears only the miss file mode bit; it also raises the machine-check trap
      if (tmo_rst) begin
         next_st.mfm[MFM_TMO_BIT] = 1'b0;
      end

      // chip reset wins over everything else
      if (chip_rst) begin
         next_st.seq          = SEQ_HOLD;
         next_st.srom_present = !st.sp_s2;
         next_st.io_mode      = 1'b0;
         next_st.fucs         = FUCS_SET_MASK;
         next_st.fucs[FUCS_IRQ_LSB +: 4] = st.irq_s2;
         next_st.pmc          = st.pmc & ~PMC_CLR_MASK;
         next_st.tx           = 1'b0;
         next_st.tlb_valid    = '0;
         next_st.mucr         = '0;
         next_st.dcmode       = '0;
         next_st.dctest       = 1'b0;
         next_st.mfm          = '0;
         next_st.cc_en        = 1'b0;
         next_st.bc_en        = 1'b0;
         next_st.cbu_cfg      = CBU_CFG_RST;
         next_st.machine_check_trap         = 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // outputs
   assign o_rdata              = st.rdata;
   assign o_cpu_reset          = st.seq != SEQ_RUN;
   assign o_boot_load_active   = st.seq == SEQ_LOAD;
   assign o_icache_inval       = st.icinv;
   assign o_dcache_inval_all   = st.dcinv;
   assign o_dcache_enable      = st.dcmode[EN_BIT];
   assign o_bcache_enable      = st.bc_en;
   assign o_cbu_config         = st.cbu_cfg;
   assign o_serial_tx          = st.tx;
   assign o_io_mode            = st.io_mode;
   assign o_clk_sel_ext        = st.pg_s2;
   assign o_timeout_reset      = tmo_rst;
   assign o_machine_check_trap = st.machine_check_trap;

   // ==========================================================
   // assertions
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);

   a_icinv_before_load: assert property (
      $rose(st.seq == SEQ_LOAD) |-> $past(st.seq) == SEQ_ICINV ##0 st.icinv)
      else $error("boot load entered without instruction cache invalidate");

   a_dcache_off_reset: assert property (
      chip_rst |=> !o_dcache_enable && !o_bcache_enable)
      else $error("cache enabled after chip reset");

   a_tx_cleared: assert property (
      chip_rst |=> !o_serial_tx)
      else $error("transmit pin not cleared by reset");

   a_fucs_reset_val: assert property (
      chip_rst |=> (st.fucs == (FUCS_SET_MASK
         | (64'($past(st.irq_s2)) << FUCS_IRQ_LSB))))
      else $error("fetch control status reset value wrong");

   a_pmc_clear: assert property (
      chip_rst |=> (st.pmc & PMC_CLR_MASK) == 64'h0)
      else $error("performance control bits not cleared");

   a_tlb_kept_tmo: assert property (
      tmo_rst && !chip_rst && !i_wr |=> st.tlb_valid == $past(st.tlb_valid)
         && st.mucr == $past(st.mucr) && st.dcmode == $past(st.dcmode))
      else $error("state lost on timeout reset");

   a_mfm_tmo_bit: assert property (
      tmo_rst && !i_wr |=> !st.mfm[MFM_TMO_BIT]
         && st.mfm[15:6] == $past(st.mfm[15:6]))
      else $error("miss file mode timeout clear wrong");

   a_cc_disabled: assert property (
      chip_rst |=> !st.cc_en)
      else $error("cycle counter enabled after chip reset");

   a_fault_locked: assert property (
      st.flock && !wr_hit_fva_rd |=> st.flock && $stable(st.fva) && $stable(st.mstat))
      else $error("fault registers changed while locked");

   a_dflush_pulse: assert property (
      i_wr && i_addr == OFS_DFLUSH |=> o_dcache_inval_all ##1 !o_dcache_inval_all)
      else $error("data cache flush not one pulse");

   a_machine_check_trap_follows: assert property (
      tmo_rst && !chip_rst |=> o_machine_check_trap)
      else $error("no machine check after timeout reset");

   c_boot_load: cover property (st.seq == SEQ_LOAD ##[1:20] st.seq == SEQ_RUN);
   c_timeout: cover property (tmo_rst ##1 o_machine_check_trap);
   c_fault_unlock: cover property (st.flock ##1 wr_hit_fva_rd ##1 !st.flock);

endmodule

// ---- sim/cris_board.sv ----
// board model: power good, system reset and test reset
module cris_board #(
   parameter int HOLD = 400
) (
   input  wire logic i_clk,
   input  wire logic i_power_on,
   input  wire logic i_reset_req,
   output logic      o_power_good,
   output logic      o_sys_reset_n,
   output logic      o_test_reset_n
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      o_power_good  = 1'h0;
      o_sys_reset_n = 1'h0;
   end
   // ==========================================================
   // reset held while power is off and HOLD cycles after
   always @(posedge i_clk) begin
      o_power_good <= i_power_on;
      if (!i_power_on || i_reset_req) begin
         cnt           <= 0;
         o_sys_reset_n <= 1'h0;
      end else if (cnt < HOLD) begin
         cnt <= cnt + 1;
      end else begin
         o_sys_reset_n <= 1'h1;
      end
   end
   assign o_test_reset_n = o_sys_reset_n && o_power_good;
endmodule

// ---- sim/cris_top_tb.sv ----
// self-checking bench of the reset and initialisation block
module cris_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cris_pkg::*;
   localparam int          TMO = 20;
   localparam logic [7:0]  KOFS [5] = '{OFS_TLB, OFS_MUCR, OFS_DCMODE, OFS_DCTEST, OFS_MFM};
   localparam logic [63:0] KMSK [5] = '{64'hFFFF, 64'hFFFF, 64'hFFFF, 64'h8000, 64'hFFFF};
   logic        i_clk = 1'h0, i_rst_n = 1'h0, power_on = 1'h0, reset_req = 1'h0;
   logic        i_power_good, i_sys_reset_n, test_reset_n;
   logic        i_srom_present_n = 1'h0, i_srom_data = 1'h0, i_srom_load_done = 1'h0;
   logic        i_instr_retire = 1'h1, i_fault_capture = 1'h0, i_wr = 1'h0, i_rd = 1'h0;
   logic [3:0]  i_irq_pins = 4'h0;
   logic [15:0] i_fault_status = 16'h0;
   logic [63:0] i_fault_va = 64'h0, i_fault_formatted_fault_address = 64'h0, i_wdata = 64'h0;
   logic [7:0]  i_addr = 8'h0;
   logic [63:0] o_rdata, vals [5], v1, v2, mon_m;
   logic [15:0] o_cbu_config;
   logic        o_cpu_reset, o_boot_load_active, o_icache_inval, o_dcache_inval_all;
   logic        o_dcache_enable, o_bcache_enable, o_serial_tx, o_io_mode, o_clk_sel_ext;
   logic        o_timeout_reset, o_machine_check_trap, rd_pend = 1'h0;
   logic [63:0] exp_q [$], msk_q [$];
   int          fail_count = 0, tests_run = 0, seed = 25891, n;
   int          ic_cnt = 0, dc_cnt = 0, mc_cnt = 0;

   cris_top #(.TMO_CYCLES (TMO)) i_cris_top (
      .i_clk, .i_rst_n, .i_power_good, .i_sys_reset_n, .i_srom_present_n, .i_srom_data,
      .i_irq_pins, .i_srom_load_done, .i_instr_retire, .i_fault_capture, .i_fault_status,
      .i_fault_va, .i_fault_formatted_fault_address, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
      .o_cpu_reset, .o_boot_load_active, .o_icache_inval, .o_dcache_inval_all,
      .o_dcache_enable, .o_bcache_enable, .o_cbu_config, .o_serial_tx, .o_io_mode,
      .o_clk_sel_ext, .o_timeout_reset, .o_machine_check_trap
   );
   cris_board i_cris_board (
      .i_clk, .i_power_on (power_on), .i_reset_req (reset_req),
      .o_power_good (i_power_good), .o_sys_reset_n (i_sys_reset_n),
      .o_test_reset_n (test_reset_n)
   );

   always #5 i_clk = ~i_clk;

   // ==========================================================
   // compare, report and finish
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic check1(input logic seen, input logic exp);
      check({63'h0, seen}, {63'h0, exp});
   endtask
   task automatic conclude();
      if (fail_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      conclude();
   end

   // ==========================================================
   // register bus and read monitor
   task automatic reg_wr(input logic [7:0] a, input logic [63:0] d);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [63:0] e, input logic [63:0] m);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'h1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge i_clk);
      i_rd <= 1'h0;
   endtask
   always @(posedge i_clk) begin
      rd_pend <= i_rd;
      if (o_icache_inval === 1'h1) ic_cnt++;
      if (o_dcache_inval_all === 1'h1) dc_cnt++;
      if (o_machine_check_trap === 1'h1) mc_cnt++;
   end
   always @(negedge i_clk) begin
      if (rd_pend) begin
         mon_m = msk_q.pop_front();
         check(o_rdata & mon_m, exp_q.pop_front() & mon_m);
      end else begin
         check(o_rdata, 64'h0);
      end
   end
   task automatic settle();
      repeat (2) @(posedge i_clk);
      #1;
   endtask

   // ==========================================================
   // chip reset, reset values and fault capture
   task automatic check_defaults(input logic rom);
      reg_rd(OFS_FUCS, FUCS_SET_MASK | {20'h0, i_irq_pins, 40'h0}, 64'hFFFF_EFBF_FFFF_FFFF);
      reg_rd(OFS_PMC, 64'h0, PMC_CLR_MASK);
      reg_rd(OFS_SLT, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF);
      for (int i = 0; i < 5; i++) reg_rd(KOFS[i], 64'h0, KMSK[i]);
      reg_rd(OFS_CCCTL, 64'h0, 64'h1);
      reg_rd(OFS_BCCTL, 64'h0, 64'h1);
      reg_rd(OFS_CBUCFG, {48'h0, CBU_CFG_RST}, 64'hFFFF);
      reg_rd(OFS_STATUS, {61'h0, 2'h2, rom}, 64'h7);
      reg_rd(8'hF8, 64'h0, 64'hFFFF_FFFF_FFFF_FFFF);
      check({48'h0, o_cbu_config}, {48'h0, CBU_CFG_RST});
      check1(o_serial_tx, 1'h0);
      check1(o_dcache_enable, 1'h0);
      check1(o_bcache_enable, 1'h0);
   endtask
   task automatic chip_reset(input logic rom, input logic pwr);
      @(posedge i_clk);
      i_srom_present_n <= ~rom;
      i_irq_pins       <= 4'($random(seed));
      power_on         <= ~pwr;
      reset_req        <= ~pwr;
      repeat (5) @(posedge i_clk);
      #1;
      check1(o_cpu_reset, 1'h1);
      check1(test_reset_n, 1'h0);
      check1(o_clk_sel_ext, ~pwr);
      ic_cnt = 0;
      @(posedge i_clk);
      power_on  <= 1'h1;
      reset_req <= 1'h0;
      n = 0;
      while (o_cpu_reset !== 1'h0 && o_boot_load_active !== 1'h1 && n < 1000) begin
         @(posedge i_clk);
         n++;
      end
      settle();
      check1(ic_cnt == 1, 1'h1);
      check1(o_boot_load_active, rom);
      if (rom) begin
         @(posedge i_clk);
         i_srom_load_done <= 1'h1;
         @(posedge i_clk);
         i_srom_load_done <= 1'h0;
      end
      settle();
      check1(o_io_mode, rom);
      check1(o_clk_sel_ext, 1'h1);
      check_defaults(rom);
   endtask
   task automatic fault(input logic [63:0] v);
      @(posedge i_clk);
      i_fault_capture <= 1'h1;
      i_fault_va      <= v;
      i_fault_formatted_fault_address <= ~v;
      i_fault_status  <= v[15:0];
      @(posedge i_clk);
      i_fault_capture <= 1'h0;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'h1;
      chip_reset(1'h1, 1'h1);
      @(posedge i_clk);
      i_srom_data <= 1'h1;
      settle();
      reg_rd(OFS_SLR, 64'h1, 64'h1);
      for (int i = 0; i < 5; i++) begin
         vals[i] = {$random(seed), $random(seed)} & KMSK[i];
         reg_wr(KOFS[i], vals[i]);
      end
      reg_wr(OFS_SLT, 64'h1);
      reg_wr(OFS_BCCTL, 64'h1);
      settle();
      check1(o_serial_tx, 1'h1);
      check1(o_bcache_enable, 1'h1);
      check1(o_dcache_enable, vals[2][0]);
      dc_cnt = 0;
      reg_wr(OFS_DFLUSH, 64'h0);
      settle();
      check1(dc_cnt == 1, 1'h1);
      ic_cnt = 0;
      reg_wr(OFS_IFLUSH, 64'h0);
      settle();
      check1(ic_cnt == 1, 1'h1);
      mc_cnt = 0;
      @(posedge i_clk);
      i_instr_retire <= 1'h0;
      n = 0;
      while (o_timeout_reset !== 1'h1 && n < 100) begin
         @(posedge i_clk);
         n++;
      end
      i_instr_retire <= 1'h1;
      check1(n >= TMO - 1 && n <= TMO + 3, 1'h1);
      settle();
      check1(mc_cnt == 1, 1'h1);
      check1(o_cpu_reset, 1'h0);
      check1(o_serial_tx, 1'h1);
      vals[4][MFM_TMO_BIT] = 1'h0;
      for (int i = 0; i < 5; i++) reg_rd(KOFS[i], vals[i], KMSK[i]);
      v1 = {$random(seed), $random(seed)};
      v2 = ~v1 ^ 64'h5A5A;
      fault(v1);
      reg_rd(OFS_STATUS, 64'h2, 64'h2);
      fault(v2);
      reg_rd(OFS_FVA, v1, 64'hFFFF_FFFF_FFFF_FFFF);
      reg_rd(OFS_FFA, ~v1, 64'hFFFF_FFFF_FFFF_FFFF);
      reg_rd(OFS_MSTAT, {48'h0, v1[15:0]}, 64'hFFFF);
      reg_rd(OFS_STATUS, 64'h0, 64'h2);
      fault(v2);
      reg_rd(OFS_FFA, ~v2, 64'hFFFF_FFFF_FFFF_FFFF);
      reg_rd(OFS_FVA, v2, 64'hFFFF_FFFF_FFFF_FFFF);
      chip_reset(1'h0, 1'h0);
      settle();
      conclude();
   end
endmodule
